// File: design/secded_guard_pkg.sv
// constants, types and code functions for the memory secded guard
package secded_guard_pkg;

   // code geometry
   localparam int DW_A = 32;
   localparam int CW_A = 7;
   localparam int DW_B = 64;
   localparam int CW_B = 8;
   localparam logic [7:0] SYN_MASK_A = 8'h3F;
   localparam logic [7:0] SYN_MASK_B = 8'h7F;

   // register map, byte addresses; memory a window starts at 0
   localparam int          ADDR_W     = 12;
   localparam logic [11:0] OFF_STAT_A = 12'h100;
   localparam logic [11:0] OFF_IE_A   = 12'h104;
   localparam logic [11:0] OFF_CNT_A  = 12'h108;
   localparam logic [11:0] OFF_INJ_A  = 12'h10C;
   localparam logic [11:0] OFF_STAT_B = 12'h110;
   localparam logic [11:0] OFF_IE_B   = 12'h114;
   localparam logic [11:0] OFF_CNT_B  = 12'h118;
   localparam logic [11:0] OFF_INJ_B  = 12'h11C;

   // field layout
   localparam int STAT_SB    = 0;
   localparam int STAT_DB    = 1;
   localparam int INJ_N_LSB  = 0;
   localparam int INJ_N_W    = 2;
   localparam int INJ_POS_LSB = 8;
   localparam int INJ_POS_W  = 7;
   localparam int CNT_W      = 16;

   // reset values
   localparam logic [1:0]  STAT_RST = 2'h0;
   localparam logic [1:0]  IE_RST   = 2'h0;
   localparam logic [15:0] CNT_RST  = 16'h0;
   localparam logic [15:0] INJ_RST  = 16'h0;

   // ahb encodings
   localparam logic       HRESP_OKAY  = 1'b0;
   localparam logic       HRESP_ERROR = 1'b1;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_WR   = 6'h02,
      S_RD   = 6'h04,
      S_RDY  = 6'h08,
      S_ERR1 = 6'h10,
      S_ERR2 = 6'h20
   } bus_state_t;

   typedef struct packed {
      logic [63:0] data;
      logic        sb;
      logic        db;
   } dec_t;

   // hamming check bits plus overall parity at bit np
   function automatic logic [7:0] check_bits(input logic [63:0] d, input int dw);
      logic [7:0] c;
      int         pos;
      int         np;
      c   = 8'h00;
      np  = (dw == 64) ? 7 : 6;
      pos = 2;
      for (int i = 0; i < 64; i++)
      begin
         if (i < dw)
         begin
            pos = pos + 1;
            if ((pos & (pos - 1)) == 0)
               pos = pos + 1;
            for (int j = 0; j < 7; j++)
               if (j < np && pos[j])
                  c[j] = c[j] ^ d[i];
         end
      end
      c[np] = (^d) ^ (^c);
      return c;
   endfunction

   // corrects one flipped bit, reports two; data left raw on a double
   function automatic dec_t decode(input logic [63:0] d, input logic [7:0] c, input int dw);
      dec_t       r;
      logic [7:0] syn;
      logic       par;
      int         pos;
      r.data = d;
      r.sb   = 1'b0;
      r.db   = 1'b0;
      syn    = (c ^ check_bits(d, dw)) & ((dw == 64) ? SYN_MASK_B : SYN_MASK_A);
      par    = (^d) ^ (^c);
      pos    = 2;
      if (par)
      begin
         r.sb = 1'b1;
         for (int i = 0; i < 64; i++)
         begin
            if (i < dw)
            begin
               pos = pos + 1;
               if ((pos & (pos - 1)) == 0)
                  pos = pos + 1;
               if (pos == int'(syn))
                  r.data[i] = ~d[i];
            end
         end
      end
      else if (syn != 8'h00)
         r.db = 1'b1;
      return r;
   endfunction

   // flips n consecutive codeword bits starting at pos, wrapping at tw
   function automatic logic [71:0] inject(input logic [71:0] code, input logic [1:0] n,
                                          input logic [6:0] pos, input int tw);
      logic [71:0] r;
      int          idx;
      r = code;
      for (int k = 0; k < 3; k++)
      begin
         if (k < int'(n))
         begin
            idx    = (int'(pos) + k) % tw;
            r[idx] = ~r[idx];
         end
      end
      return r;
   endfunction

endpackage

// File: design/secded_guard.sv
// secded guard for a bus-read 32-bit memory and a datapath-read 64-bit memory
`timescale 1ns/100ps

module secded_guard #(
   parameter int A_AW = 6,
   parameter int B_AW = 5
) (
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // datapath port of memory b
   input  wire logic              b_wr_en,
   input  wire logic [B_AW-1:0]   b_wr_addr,
   input  wire logic [63:0]       b_wr_data,
   input  wire logic              b_rd_en,
   input  wire logic [B_AW-1:0]   b_rd_addr,
   output logic                   b_rd_valid,
   output logic      [63:0]       b_rd_data,
   output logic                   b_rd_err,
   // interrupt
   output logic                   irq
);

   localparam int A_DEPTH = 1 << A_AW;
   localparam int B_DEPTH = 1 << B_AW;

   typedef struct packed {
      secded_guard_pkg::bus_state_t bst;
      logic [11:0]                  addr;
      logic                         hready;
      logic                         hresp;
      logic [31:0]                  hrdata;
      logic [1:0]                   stat_a;
      logic [1:0]                   stat_b;
      logic [1:0]                   ie_a;
      logic [1:0]                   ie_b;
      logic [15:0]                  cnt_a;
      logic [15:0]                  cnt_b;
      logic [15:0]                  inj_a;
      logic [15:0]                  inj_b;
      logic                         irq;
      logic                         b_valid;
      logic [63:0]                  b_data;
      logic                         b_err;
   } state_t;

   state_t                 st_r;
   state_t                 st_nxt;
   logic [38:0]            mem_a [A_DEPTH];
   logic [71:0]            mem_b [B_DEPTH];
   logic                   accept;
   logic                   in_mem_a;
   logic [A_AW-1:0]        a_idx;
   logic [38:0]            a_word;
   logic [71:0]            b_word;
   secded_guard_pkg::dec_t dec_a;
   secded_guard_pkg::dec_t dec_b;
   logic                   rd_a;
   logic                   wr_a;
   logic                   clr_a;
   logic                   clr_b;
   logic [1:0]             set_a;
   logic [1:0]             set_b;
   logic [71:0]            code_a;
   logic [71:0]            code_b;
   logic [7:0]             chk_a;
   logic [7:0]             chk_b;
   logic [31:0]            reg_rd;

   // register read mux, zero above each field
   function automatic logic [31:0] reg_read(input state_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (s.addr)
         secded_guard_pkg::OFF_STAT_A: v = 32'(s.stat_a);
         secded_guard_pkg::OFF_IE_A:   v = 32'(s.ie_a);
         secded_guard_pkg::OFF_CNT_A:  v = 32'(s.cnt_a);
         secded_guard_pkg::OFF_INJ_A:  v = 32'(s.inj_a);
         secded_guard_pkg::OFF_STAT_B: v = 32'(s.stat_b);
         secded_guard_pkg::OFF_IE_B:   v = 32'(s.ie_b);
         secded_guard_pkg::OFF_CNT_B:  v = 32'(s.cnt_b);
         secded_guard_pkg::OFF_INJ_B:  v = 32'(s.inj_b);
         default:                      v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // memory a occupies the first A_DEPTH words of the slave window
   function automatic logic is_mem_a(input logic [11:0] a);
      return (32'(a) >> 2) < A_DEPTH;
   endfunction

   assign accept   = hsel && hready && htrans[1];
   assign in_mem_a = is_mem_a(st_r.addr);
   assign a_idx    = st_r.addr[2 +: A_AW];
   assign a_word   = mem_a[a_idx];
   assign b_word   = mem_b[b_rd_addr];
   assign dec_a    = secded_guard_pkg::decode({32'h0000_0000, a_word[31:0]}, {1'b0, a_word[38:32]},
                                              secded_guard_pkg::DW_A);
   assign dec_b    = secded_guard_pkg::decode(b_word[63:0], b_word[71:64], secded_guard_pkg::DW_B);
   assign rd_a     = (st_r.bst == secded_guard_pkg::S_RD) && in_mem_a;
   assign wr_a     = (st_r.bst == secded_guard_pkg::S_WR) && in_mem_a;
   assign clr_a    = (st_r.bst == secded_guard_pkg::S_RD) && (st_r.addr == secded_guard_pkg::OFF_STAT_A);
   assign clr_b    = (st_r.bst == secded_guard_pkg::S_RD) && (st_r.addr == secded_guard_pkg::OFF_STAT_B);
   assign set_a    = rd_a ? {dec_a.db, dec_a.sb} : 2'h0;
   assign set_b    = b_rd_en ? {dec_b.db, dec_b.sb} : 2'h0;
   assign chk_a    = secded_guard_pkg::check_bits({32'h0000_0000, hwdata}, secded_guard_pkg::DW_A);
   assign chk_b    = secded_guard_pkg::check_bits(b_wr_data, secded_guard_pkg::DW_B);
   assign reg_rd   = reg_read(st_r);

   // injection acts on the encoded word so check bits can be hit too
   assign code_a = secded_guard_pkg::inject({33'h0, chk_a[6:0], hwdata},
                      st_r.inj_a[secded_guard_pkg::INJ_N_LSB +: secded_guard_pkg::INJ_N_W],
                      st_r.inj_a[secded_guard_pkg::INJ_POS_LSB +: secded_guard_pkg::INJ_POS_W],
                      secded_guard_pkg::DW_A + secded_guard_pkg::CW_A);
   assign code_b = secded_guard_pkg::inject({chk_b, b_wr_data},
                      st_r.inj_b[secded_guard_pkg::INJ_N_LSB +: secded_guard_pkg::INJ_N_W],
                      st_r.inj_b[secded_guard_pkg::INJ_POS_LSB +: secded_guard_pkg::INJ_POS_W],
                      secded_guard_pkg::DW_B + secded_guard_pkg::CW_B);

   // storage has no reset; contents are undefined until written
   always_ff @(posedge hclk)
   begin
      if (wr_a)
         mem_a[a_idx] <= code_a[38:0];
      if (b_wr_en)
         mem_b[b_wr_addr] <= code_b;
   end

   always_comb
   begin
      st_nxt = st_r;

      // bus sequencing; reads take one wait state for decode
      case (st_r.bst)
         secded_guard_pkg::S_WR:
         begin
            st_nxt.bst = secded_guard_pkg::S_IDLE;
         end
         secded_guard_pkg::S_RD:
         begin
            if (in_mem_a && dec_a.db)
            begin
               st_nxt.bst    = secded_guard_pkg::S_ERR1;
               st_nxt.hresp  = secded_guard_pkg::HRESP_ERROR;
               st_nxt.hready = 1'b0;
               st_nxt.hrdata = a_word[31:0];
            end
            else
            begin
               st_nxt.bst    = secded_guard_pkg::S_RDY;
               st_nxt.hready = 1'b1;
               st_nxt.hrdata = in_mem_a ? dec_a.data[31:0] : reg_rd;
            end
         end
         secded_guard_pkg::S_RDY:
         begin
            st_nxt.bst = secded_guard_pkg::S_IDLE;
         end
         secded_guard_pkg::S_ERR1:
         begin
            st_nxt.bst    = secded_guard_pkg::S_ERR2;
            st_nxt.hready = 1'b1;
         end
         secded_guard_pkg::S_ERR2:
         begin
            st_nxt.bst   = secded_guard_pkg::S_IDLE;
            st_nxt.hresp = secded_guard_pkg::HRESP_OKAY;
         end
         default:
         begin
            st_nxt.bst    = secded_guard_pkg::S_IDLE;
            st_nxt.hready = 1'b1;
         end
      endcase

      // new address phase is only seen while hready is high
      if (accept)
      begin
         st_nxt.addr   = haddr[secded_guard_pkg::ADDR_W-1:0];
         st_nxt.bst    = hwrite ? secded_guard_pkg::S_WR : secded_guard_pkg::S_RD;
         st_nxt.hready = hwrite;
         st_nxt.hresp  = secded_guard_pkg::HRESP_OKAY;
      end

      // register writes in the write data phase
      if (st_r.bst == secded_guard_pkg::S_WR)
      begin
         case (st_r.addr)
            secded_guard_pkg::OFF_IE_A:  st_nxt.ie_a  = hwdata[1:0];
            secded_guard_pkg::OFF_IE_B:  st_nxt.ie_b  = hwdata[1:0];
            secded_guard_pkg::OFF_CNT_A: st_nxt.cnt_a = hwdata[15:0];
            secded_guard_pkg::OFF_CNT_B: st_nxt.cnt_b = hwdata[15:0];
            secded_guard_pkg::OFF_INJ_A: st_nxt.inj_a = hwdata[15:0];
            secded_guard_pkg::OFF_INJ_B: st_nxt.inj_b = hwdata[15:0];
            default:
            begin
            end
         endcase
      end

      // injection is one-shot: disarmed by the write it corrupts
      if (wr_a)
         st_nxt.inj_a[secded_guard_pkg::INJ_N_LSB +: secded_guard_pkg::INJ_N_W] = 2'h0;
      if (b_wr_en)
         st_nxt.inj_b[secded_guard_pkg::INJ_N_LSB +: secded_guard_pkg::INJ_N_W] = 2'h0;

      // status: read clears, a same-cycle event still lands
      st_nxt.stat_a = (clr_a ? 2'h0 : st_r.stat_a) | set_a;
      st_nxt.stat_b = (clr_b ? 2'h0 : st_r.stat_b) | set_b;
      if ((|set_a) && (st_r.cnt_a != 16'hFFFF))
         st_nxt.cnt_a = st_r.cnt_a + 16'h0001;
      if ((|set_b) && (st_r.cnt_b != 16'hFFFF))
         st_nxt.cnt_b = st_r.cnt_b + 16'h0001;

      // datapath read: corrupted word goes on, flagged, never stalled
      st_nxt.b_valid = b_rd_en;
      st_nxt.b_err   = b_rd_en && dec_b.db;
      if (b_rd_en)
         st_nxt.b_data = dec_b.db ? b_word[63:0] : dec_b.data;

      st_nxt.irq = (|(st_nxt.stat_a & st_nxt.ie_a)) || (|(st_nxt.stat_b & st_nxt.ie_b));
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r         <= '0;
         st_r.bst     <= secded_guard_pkg::S_IDLE;
         st_r.hready  <= 1'b1;
         st_r.hresp   <= secded_guard_pkg::HRESP_OKAY;
         st_r.stat_a  <= secded_guard_pkg::STAT_RST;
         st_r.stat_b  <= secded_guard_pkg::STAT_RST;
         st_r.ie_a    <= secded_guard_pkg::IE_RST;
         st_r.ie_b    <= secded_guard_pkg::IE_RST;
         st_r.cnt_a   <= secded_guard_pkg::CNT_RST;
         st_r.cnt_b   <= secded_guard_pkg::CNT_RST;
         st_r.inj_a   <= secded_guard_pkg::INJ_RST;
         st_r.inj_b   <= secded_guard_pkg::INJ_RST;
      end
      else
         st_r <= st_nxt;
   end

   assign hrdata     = st_r.hrdata;
   assign hreadyout  = st_r.hready;
   assign hresp      = st_r.hresp;
   assign b_rd_valid = st_r.b_valid;
   assign b_rd_data  = st_r.b_data;
   assign b_rd_err   = st_r.b_err;
   assign irq        = st_r.irq;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_rd_a_db;
      rd_a && dec_a.db;
   endsequence

   sequence s_err_two_cycle;
      (hresp && !hreadyout) ##1 (hresp && hreadyout);
   endsequence

   a_db_bus_error: assert property (s_rd_a_db |=> s_err_two_cycle)
      else $error("double error read not answered with two-cycle error");
   a_db_raw_data: assert property (s_rd_a_db |=> hrdata == $past(a_word[31:0]))
      else $error("double error data was altered");
   a_sb_fixed: assert property ((rd_a && dec_a.sb) |=> !hresp && hreadyout &&
                                 ($countones(hrdata ^ $past(a_word[31:0])) <= 1))
      else $error("single error read not corrected cleanly");
   a_irq_gate: assert property (irq == ((|(st_r.stat_a & st_r.ie_a)) || (|(st_r.stat_b & st_r.ie_b))))
      else $error("interrupt does not match enabled status");
   a_b_pass_raw: assert property ((b_rd_en && dec_b.db) |=>
                                  b_rd_valid && b_rd_err && b_rd_data == $past(b_word[63:0]))
      else $error("datapath did not pass corrupted word with flag");
   a_b_db_flag: assert property ((b_rd_en && dec_b.db) |=> st_r.stat_b[secded_guard_pkg::STAT_DB])
      else $error("datapath double error not recorded");
   a_inj_oneshot: assert property ((wr_a && st_r.inj_a[1:0] != 2'h0) |=> st_r.inj_a[1:0] == 2'h0)
      else $error("injection stayed armed after write");
   a_count_step: assert property (((|set_a) && st_r.cnt_a != 16'hFFFF) |=>
                                  st_r.cnt_a == $past(st_r.cnt_a) + 16'h0001)
      else $error("error count did not step once");
   a_stat_sticky: assert property ((st_r.stat_a[secded_guard_pkg::STAT_DB] && !clr_a) |=>
                                   st_r.stat_a[secded_guard_pkg::STAT_DB])
      else $error("double error flag dropped without a read");
   a_mem_indep: assert property (((|set_b) && !(|set_a) && !clr_a) |=> $stable(st_r.stat_a))
      else $error("memory b event touched memory a status");

   // interrupt follows the event edge when its enable is already set
   a_irq_a_db: assert property ((rd_a && dec_a.db && st_r.ie_a[secded_guard_pkg::STAT_DB]) |=> irq)
      else $error("enabled memory a double error did not raise the interrupt");
   a_irq_b_db: assert property ((b_rd_en && dec_b.db && st_r.ie_b[secded_guard_pkg::STAT_DB]) |=> irq)
      else $error("enabled datapath double error did not raise the interrupt");

   // register reads never answer with an error
   a_reg_rd_okay: assert property (((st_r.bst == secded_guard_pkg::S_RD) && !in_mem_a) |=>
                                   !hresp && hreadyout)
      else $error("register read answered with an error");

   // datapath side: one valid pulse per read, singles fixed quietly
   a_b_valid_pulse: assert property (b_rd_valid == $past(b_rd_en))
      else $error("datapath valid is not the read strobe delayed by one");
   a_b_sb_fixed: assert property ((b_rd_en && dec_b.sb) |=> !b_rd_err &&
                                  ($countones(b_rd_data ^ $past(b_word[63:0])) <= 1))
      else $error("datapath single error not corrected cleanly");
   a_count_b_step: assert property (((|set_b) && st_r.cnt_b != 16'hFFFF) |=>
                                    st_r.cnt_b == $past(st_r.cnt_b) + 16'h0001)
      else $error("memory b error count did not step once");

   sequence s_b_clean_valid;
      b_rd_valid && !b_rd_err;
   endsequence

   a_b_err_only_db: assert property ((b_rd_en && !dec_b.db) |=> s_b_clean_valid)
      else $error("datapath flagged a word that was not uncorrectable");

   // status reads clear; only an event in the clearing cycle survives
   a_stat_a_clear: assert property (clr_a |=> st_r.stat_a == 2'h0)
      else $error("memory a status not cleared by its read");
   a_stat_b_clear: assert property ((clr_b && !b_rd_en) |=> st_r.stat_b == 2'h0)
      else $error("memory b status not cleared by its read");
   a_stat_b_sticky: assert property ((st_r.stat_b[secded_guard_pkg::STAT_DB] && !clr_b) |=>
                                     st_r.stat_b[secded_guard_pkg::STAT_DB])
      else $error("memory b double error flag dropped without a read");
   a_inj_b_oneshot: assert property ((b_wr_en && st_r.inj_b[1:0] != 2'h0) |=> st_r.inj_b[1:0] == 2'h0)
      else $error("memory b injection stayed armed after write");

endmodule

// File: tb/dp_partner.sv
// datapath consumer model of memory b: writes words and collects read results
`timescale 1ns/100ps
module dp_partner #(
   parameter int AW = 5
) (
   // clock
   input  wire logic          hclk,
   // memory b datapath
   output logic               b_wr_en,
   output logic [AW-1:0]      b_wr_addr,
   output logic [63:0]        b_wr_data,
   output logic               b_rd_en,
   output logic [AW-1:0]      b_rd_addr,
   input  wire logic          b_rd_valid,
   input  wire logic [63:0]   b_rd_data,
   input  wire logic          b_rd_err
);
   initial
   begin
      b_wr_en   = 1'b0;
      b_wr_addr = '0;
      b_wr_data = 64'h0;
      b_rd_en   = 1'b0;
      b_rd_addr = '0;
   end

   // one-cycle write pulse; data inverted afterwards so nothing stale looks valid
   task automatic put(input logic [AW-1:0] a, input logic [63:0] d);
      b_wr_en   <= 1'b1;
      b_wr_addr <= a;
      b_wr_data <= d;
      @(posedge hclk);
      b_wr_en   <= 1'b0;
      b_wr_data <= ~d;
      @(posedge hclk);
   endtask

   // gap idles first, so the consumer can be prompt or slow
   task automatic get(input logic [AW-1:0] a, input int gap,
                      output logic [63:0] d, output logic e, output logic v);
      repeat (gap) @(posedge hclk);
      b_rd_en   <= 1'b1;
      b_rd_addr <= a;
      @(posedge hclk);
      b_rd_en   <= 1'b0;
      b_rd_addr <= ~a;
      @(posedge hclk);
      d = b_rd_data;
      e = b_rd_err;
      v = b_rd_valid;
   endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the memory secded guard
`timescale 1ns/100ps
module tb_top;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        b_wr_en;
   logic [4:0]  b_wr_addr;
   logic [63:0] b_wr_data;
   logic        b_rd_en;
   logic [4:0]  b_rd_addr;
   logic        b_rd_valid;
   logic [63:0] b_rd_data;
   logic        b_rd_err;
   logic        irq;
   int          num_errors = 0;
   int          checks = 0;
   int          cycles = 0;
   logic [31:0] rd;
   logic        rs;
   logic [63:0] wd;
   logic        we;
   logic        wv;
   logic [63:0] dw = 64'h0123_4567_89AB_CDEF;

   secded_guard #(.A_AW(6), .B_AW(5)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .b_wr_en(b_wr_en), .b_wr_addr(b_wr_addr),
      .b_wr_data(b_wr_data), .b_rd_en(b_rd_en), .b_rd_addr(b_rd_addr),
      .b_rd_valid(b_rd_valid), .b_rd_data(b_rd_data), .b_rd_err(b_rd_err), .irq(irq));

   dp_partner #(.AW(5)) u_dp (
      .hclk(hclk), .b_wr_en(b_wr_en), .b_wr_addr(b_wr_addr), .b_wr_data(b_wr_data),
      .b_rd_en(b_rd_en), .b_rd_addr(b_rd_addr), .b_rd_valid(b_rd_valid),
      .b_rd_data(b_rd_data), .b_rd_err(b_rd_err));

   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // run needs well under a thousand cycles
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         results();
      end
   end

   task automatic results();
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_wide(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // single ahb-lite transfer; address held until hready, then data phase until hready
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {20'h00000, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rd = hrdata;
      rs = hresp;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask

   task automatic rdx(input logic [11:0] a, input logic [31:0] exp, input logic er);
      ahb(1'b0, a, 32'h0);
      chk_word(rd, exp);
      chk_word({31'h0, rs}, {31'h0, er});
   endtask

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge hclk);
      chk_word({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic dpchk(input logic [4:0] a, input int gap, input logic [63:0] exp, input logic e);
      u_dp.get(a, gap, wd, we, wv);
      chk_wide(wd, exp);
      chk_word({30'h0, wv, we}, {30'h0, 1'b1, e});
   endtask

   initial
   begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hwdata  = 32'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_word({31'h0, irq}, 32'h0);
      for (int i = 0; i < 8; i++)
         rdx(secded_guard_pkg::OFF_STAT_A + 12'(4 * i), 32'h0, 1'b0);
      wr(12'h00C, 32'hA5A5_1234);
      rdx(12'h00C, 32'hA5A5_1234, 1'b0);
      wr(secded_guard_pkg::OFF_INJ_A, 32'h0000_0501);
      wr(12'h010, 32'h1357_9BDF);
      rdx(secded_guard_pkg::OFF_INJ_A, 32'h0000_0500, 1'b0);
      rdx(12'h010, 32'h1357_9BDF, 1'b0);
      rdx(secded_guard_pkg::OFF_STAT_A, 32'h1, 1'b0);
      rdx(secded_guard_pkg::OFF_STAT_A, 32'h0, 1'b0);
      wr(secded_guard_pkg::OFF_IE_A, 32'h2);
      wr(secded_guard_pkg::OFF_INJ_A, 32'h0000_0002);
      wr(12'h014, 32'hCAFE_0F0F);
      rdx(12'h014, 32'hCAFE_0F0C, 1'b1);
      irq_is(1'b1);
      rdx(secded_guard_pkg::OFF_STAT_A, 32'h2, 1'b0);
      irq_is(1'b0);
      wr(secded_guard_pkg::OFF_IE_A, 32'h0);
      wr(secded_guard_pkg::OFF_INJ_A, 32'h0000_0002);
      wr(12'h018, 32'h0000_FFFF);
      rdx(12'h018, 32'h0000_FFFC, 1'b1);
      irq_is(1'b0);
      // three flips: odd parity, so it lands as a (mis)corrected single
      wr(secded_guard_pkg::OFF_INJ_A, 32'h0000_0A03);
      wr(12'h01C, 32'h8765_4321);
      ahb(1'b0, 12'h01C, 32'h0);
      chk_word({31'h0, rs}, 32'h0);
      rdx(secded_guard_pkg::OFF_CNT_A, 32'h4, 1'b0);
      rdx(secded_guard_pkg::OFF_STAT_A, 32'h3, 1'b0);
      wr(secded_guard_pkg::OFF_STAT_A, 32'h3);
      rdx(secded_guard_pkg::OFF_STAT_A, 32'h0, 1'b0);
      rdx(12'h200, 32'h0, 1'b0);
      wr(secded_guard_pkg::OFF_IE_B, 32'h2);
      u_dp.put(5'h02, dw);
      dpchk(5'h02, 0, dw, 1'b0);
      wr(secded_guard_pkg::OFF_INJ_B, 32'h0000_0001);
      u_dp.put(5'h03, dw);
      dpchk(5'h03, 3, dw, 1'b0);
      irq_is(1'b0);
      rdx(secded_guard_pkg::OFF_STAT_B, 32'h1, 1'b0);
      wr(secded_guard_pkg::OFF_INJ_B, 32'h0000_3E02);
      u_dp.put(5'h04, dw);
      dpchk(5'h04, 0, dw ^ 64'hC000_0000_0000_0000, 1'b1);
      irq_is(1'b1);
      rdx(secded_guard_pkg::OFF_STAT_B, 32'h2, 1'b0);
      irq_is(1'b0);
      rdx(secded_guard_pkg::OFF_CNT_B, 32'h2, 1'b0);
      rdx(secded_guard_pkg::OFF_CNT_A, 32'h4, 1'b0);
      // the count is writable so software can rebase it
      wr(secded_guard_pkg::OFF_CNT_A, 32'h0000_0010);
      rdx(secded_guard_pkg::OFF_CNT_A, 32'h0000_0010, 1'b0);
      results();
   end
endmodule
